// File: src/tad_pkg.sv
// Package for the touch activation detect block: register map, fields, timing
// Functional notes
// - Stage results stored at 0x00B through 0x012
// - Results are unsigned 16-bit values
// - Per-stage input select through switch matrix
// - Active when result above upper or below lower
// - Either input side activates on a rise or a fall
// - Limits adapt by calibration, no host writes
// - Limits loaded from seeds at power-up
// - Alert raised when new result data stored
// - Alert open-drain with selectable polarity
// - Calibration state kept in 528-word memory
// - Button detection done fully on chip
// - Sequencer polls stages in order with settings
// - Full power and low power wake-up modes
// - Power field: 00 full, 10 low, else shutdown
// - Low power touched: sequence every 25 ms
package tad_pkg;
  localparam int NUM_STAGES = 8;
  localparam int RES_W = 16;
  localparam int ADDR_W = 10;
  localparam int CAL_WORDS = 528;
  localparam int CAL_AW = 10;
  // Register map (word addresses)
  localparam logic [ADDR_W-1:0] ADDR_PWR_CTRL = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ALERT_CFG = 10'h001;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE = 10'h009;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_FIRST = 10'h00B;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LAST = 10'h012;
  localparam logic [ADDR_W-1:0] ADDR_SETUP_BASE = 10'h080;
  localparam logic [ADDR_W-1:0] ADDR_SEED_HI_BASE = 10'h088;
  localparam logic [ADDR_W-1:0] ADDR_SEED_LO_BASE = 10'h090;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_HI_BASE = 10'h0A0;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_LO_BASE = 10'h0A8;
  // Power control fields
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_SEQ_LAST_LSB = 4;
  localparam logic [1:0] PWR_MODE_FULL = 2'h0;
  localparam logic [1:0] PWR_MODE_LOW = 2'h2;
  localparam logic [15:0] PWR_CTRL_RESET = 16'h0070;
  // Alert config: bit0 polarity (1 = active high), bit1 alert on touch only
  localparam int ALERT_POL_BIT = 0;
  localparam int ALERT_TOUCH_BIT = 1;
  localparam logic [15:0] ALERT_CFG_RESET = 16'h0000;
  // Stage setup fields: [2:0] input select, [3] negative side, [5:4] cal shift
  localparam int SETUP_SEL_LSB = 0;
  localparam int SETUP_NEG_BIT = 3;
  localparam int SETUP_SHIFT_LSB = 4;
  localparam logic [15:0] SETUP_RESET = 16'h0010;
  localparam logic [15:0] SEED_HI_RESET = 16'hFFFF;
  localparam logic [15:0] SEED_LO_RESET = 16'h0000;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int LP_PERIOD_MS = 25;
  localparam int LP_PERIOD_CYC = CLK_HZ / 1000 * LP_PERIOD_MS;
  localparam int LP_IDLE_MS = 200;
  localparam int LP_IDLE_CYC = CLK_HZ / 1000 * LP_IDLE_MS;

  typedef struct packed {
    logic [2:0] stage;
    logic [RES_W-1:0] value;
  } tad_sample_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } tad_reg_req_type;
endpackage

// File: src/tad_cal_ram.sv
// Calibration state memory with registered read data
`timescale 1ns/1ps
module tad_cal_ram #(
  parameter int DEPTH = 528,
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: src/tad_link_cdc.sv
// Handshake crossing of one stage sample from the converter clock domain
`timescale 1ns/1ps
module tad_link_cdc (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic sample_valid,
  input tad_pkg::tad_sample_type sample_in,
  output logic sample_ready,
  input wire logic clk,
  input wire logic rst_n,
  output logic out_pulse,
  output tad_pkg::tad_sample_type sample_out
);
  import tad_pkg::*;
  typedef struct packed {
    logic req;
    logic ack_s1;
    logic ack_s2;
    tad_sample_type hold;
  } tad_src_type;
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    tad_sample_type data;
    logic pulse;
  } tad_dst_type;
  tad_src_type s_q, s_d;
  tad_dst_type d_q, d_d;

  // Source is free when request and returned acknowledge agree
  assign sample_ready = (s_q.req == s_q.ack_s2);
  always_comb begin
    s_d = s_q;
    s_d.ack_s1 = d_q.req_s2;
    s_d.ack_s2 = s_q.ack_s1;
    if (sample_valid && sample_ready) begin
      s_d.hold = sample_in;
      s_d.req = ~s_q.req;
    end
  end
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    d_d = d_q;
    d_d.req_s1 = s_q.req;
    d_d.req_s2 = d_q.req_s1;
    d_d.req_s3 = d_q.req_s2;
    // Held data is stable for the whole handshake, so sampling it here is safe
    d_d.pulse = d_q.req_s2 ^ d_q.req_s3;
    if (d_q.req_s2 ^ d_q.req_s3) begin
      d_d.data = s_q.hold;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_q <= '0;
    end else begin
      d_q <= d_d;
    end
  end
  assign out_pulse = d_q.pulse;
  assign sample_out = d_q.data;
endmodule

// File: src/tad_core.sv
// Touch activation detect: result registers, limits, calibration, sequencer, alert
`timescale 1ns/1ps
module tad_core #(
  parameter int LP_PERIOD_CYCLES = tad_pkg::LP_PERIOD_CYC,
  parameter int LP_IDLE_CYCLES = tad_pkg::LP_IDLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_clk,
  input wire logic conv_rst_n,
  input wire logic conv_valid,
  input wire logic [tad_pkg::RES_W-1:0] conv_value,
  output logic conv_ready,
  output logic [2:0] conv_stage,
  output logic [2:0] conv_input_sel,
  output logic [15:0] conv_setup,
  output logic conv_start,
  output logic conv_power_on,
  input tad_pkg::tad_reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic alert_o,
  output logic alert_oe_n,
  output logic [tad_pkg::NUM_STAGES-1:0] stage_active
);
  import tad_pkg::*;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_IDLE,
    ST_CONVERT,
    ST_WAIT
  } tad_seq_type;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_READ,
    CAL_UPDATE
  } tad_cal_type;

  typedef struct packed {
    tad_seq_type seq;
    tad_cal_type cal;
    logic [2:0] stage;
    logic [2:0] init_idx;
    logic [31:0] timer;
    logic [15:0] pwr_ctrl;
    logic [15:0] alert_cfg;
    logic [NUM_STAGES-1:0][15:0] setup;
    logic [NUM_STAGES-1:0][15:0] seed_hi;
    logic [NUM_STAGES-1:0][15:0] seed_lo;
    logic [NUM_STAGES-1:0][15:0] lim_hi;
    logic [NUM_STAGES-1:0][15:0] lim_lo;
    logic [NUM_STAGES-1:0][RES_W-1:0] result;
    logic [NUM_STAGES-1:0] active;
    logic alert;
    logic start;
    logic [15:0] rdata;
    logic rvalid;
    logic [2:0] cal_stage;
    logic [RES_W-1:0] cal_value;
  } tad_state_type;

  tad_state_type s_q, s_d;
  tad_sample_type link_sample;
  tad_sample_type new_sample;
  logic new_pulse;
  logic cal_we;
  logic [CAL_AW-1:0] cal_waddr;
  logic [15:0] cal_wdata;
  logic [CAL_AW-1:0] cal_raddr;
  logic [15:0] cal_rdata;
  logic [1:0] mode;
  logic any_active;
  logic cmp_hi;
  logic cmp_lo;
  logic [3:0] seq_last;
  logic [NUM_STAGES-1:0] next_active;
  logic [15:0] ambient;
  logic [15:0] band;
  logic [1:0] shift;

  // Stage number in the converter domain is tracked locally per sample
  logic [2:0] conv_stage_link_q;
  logic [2:0] seq_last_s1_q;
  logic [2:0] seq_last_link_q;
  logic conv_take;
  assign link_sample = {conv_stage_link_q, conv_value};
  assign conv_take = conv_valid && conv_ready;
  always_ff @(posedge conv_clk or negedge conv_rst_n) begin
    if (!conv_rst_n) begin
      conv_stage_link_q <= 3'h0;
    end else if (conv_take) begin
      conv_stage_link_q <= (conv_stage_link_q == seq_last_link_q) ? 3'h0 : conv_stage_link_q + 3'h1;
    end
  end
  // Sequence length crossed to the converter domain as a slow level
  always_ff @(posedge conv_clk or negedge conv_rst_n) begin
    if (!conv_rst_n) begin
      seq_last_s1_q <= 3'h7;
      seq_last_link_q <= 3'h7;
    end else begin
      seq_last_s1_q <= s_q.pwr_ctrl[PWR_SEQ_LAST_LSB +: 3];
      seq_last_link_q <= seq_last_s1_q;
    end
  end

  tad_link_cdc u_link (
    .link_clk(conv_clk),
    .link_rst_n(conv_rst_n),
    .sample_valid(conv_valid),
    .sample_in(link_sample),
    .sample_ready(conv_ready),
    .clk(clk),
    .rst_n(rst_n),
    .out_pulse(new_pulse),
    .sample_out(new_sample)
  );

  tad_cal_ram #(
    .DEPTH(CAL_WORDS),
    .AW(CAL_AW),
    .DW(16)
  ) u_cal_ram (
    .clk(clk),
    .we(cal_we),
    .waddr(cal_waddr),
    .wdata(cal_wdata),
    .raddr(cal_raddr),
    .rdata(cal_rdata)
  );

  assign mode = s_q.pwr_ctrl[PWR_MODE_LSB +: 2];
  assign seq_last = s_q.pwr_ctrl[PWR_SEQ_LAST_LSB +: 4];
  assign any_active = |s_q.active;
  // Ambient word per stage lives at the stage index in the memory
  assign cal_raddr = {7'h00, s_q.cal_stage};
  // Ambient words are cleared during init, so tracking starts from zero instead of power-up garbage
  assign cal_waddr = (s_q.seq == ST_INIT) ? {7'h00, s_q.init_idx} : {7'h00, s_q.cal_stage};
  assign shift = s_q.setup[s_q.cal_stage][SETUP_SHIFT_LSB +: 2];
  assign band = s_q.seed_hi[s_q.cal_stage] - s_q.seed_lo[s_q.cal_stage];

  assign cmp_hi = new_sample.value > s_q.lim_hi[new_sample.stage];
  assign cmp_lo = new_sample.value < s_q.lim_lo[new_sample.stage];

  // touch direction is the same for both converter sides: above upper or below lower
  always_comb begin
    next_active = s_q.active;
    if (s_q.setup[new_sample.stage][SETUP_NEG_BIT]) begin
      next_active[new_sample.stage] = cmp_lo || cmp_hi;
    end else begin
      next_active[new_sample.stage] = cmp_hi || cmp_lo;
    end
  end

  // Ambient tracks slowly toward untouched results; touched stages freeze it
  always_comb begin
    ambient = cal_rdata;
    if (s_q.cal_value > cal_rdata) begin
      ambient = cal_rdata + ((s_q.cal_value - cal_rdata) >> ({1'b0, shift} + 3'h1));
    end else begin
      ambient = cal_rdata - ((cal_rdata - s_q.cal_value) >> ({1'b0, shift} + 3'h1));
    end
  end
  assign cal_we = (s_q.seq == ST_INIT) || ((s_q.cal == CAL_UPDATE) && !s_q.active[s_q.cal_stage]);
  assign cal_wdata = (s_q.seq == ST_INIT) ? 16'h0000 : ambient;

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rvalid = 1'b0;

    // each sample lands in its own result register
    if (new_pulse && s_q.seq != ST_INIT) begin
      s_d.result[new_sample.stage] = new_sample.value;
      // switch matrix follows the stage converted next
      s_d.stage = ({1'b0, new_sample.stage} == seq_last) ? 3'h0 : new_sample.stage + 3'h1;
      // comparison uses the sample being written this cycle
      s_d.active = next_active;
      if (!s_q.alert_cfg[ALERT_TOUCH_BIT] || |next_active) begin
        s_d.alert = 1'b1;
      end
      s_d.cal_stage = new_sample.stage;
      s_d.cal_value = new_sample.value;
      s_d.cal = CAL_READ;
    end

    // limits follow ambient without host involvement
    case (s_q.cal)
      CAL_IDLE: begin
      end
      CAL_READ: begin
        s_d.cal = CAL_UPDATE;
      end
      CAL_UPDATE: begin
        if (!s_q.active[s_q.cal_stage] && cal_rdata != 16'h0000) begin
          s_d.lim_hi[s_q.cal_stage] = ambient + (band >> 1);
          s_d.lim_lo[s_q.cal_stage] = ambient - (band >> 1);
        end
        // A sample landing in this cycle starts its own update
        if (!new_pulse || s_q.seq == ST_INIT) begin
          s_d.cal = CAL_IDLE;
        end
      end
      default: begin
        s_d.cal = CAL_IDLE;
      end
    endcase

    case (s_q.seq)
      ST_INIT: begin
        // limits start from the seed values
        s_d.lim_hi[s_q.init_idx] = s_q.seed_hi[s_q.init_idx];
        s_d.lim_lo[s_q.init_idx] = s_q.seed_lo[s_q.init_idx];
        s_d.init_idx = s_q.init_idx + 3'h1;
        if (s_q.init_idx == 3'h7) begin
          s_d.seq = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (mode == PWR_MODE_FULL || mode == PWR_MODE_LOW) begin
          s_d.start = 1'b1;
          s_d.seq = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        // shutdown abandons the running sequence at once
        if (mode[0]) begin
          s_d.seq = ST_IDLE;
        end else if (new_pulse && {1'b0, new_sample.stage} == seq_last) begin
          if (mode == PWR_MODE_FULL) begin
            s_d.start = 1'b1;
          end else begin
            s_d.timer = (any_active || |next_active) ? 32'(LP_PERIOD_CYCLES - 1) : 32'(LP_IDLE_CYCLES - 1);
            s_d.seq = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (mode != PWR_MODE_LOW) begin
          s_d.seq = ST_IDLE;
        end else if (s_q.timer == 32'h0) begin
          s_d.start = 1'b1;
          s_d.seq = ST_CONVERT;
        end else begin
          s_d.timer = s_q.timer - 32'h1;
        end
      end
      default: begin
        s_d.seq = ST_IDLE;
      end
    endcase

    // Register port: reads of the active register clear the alert, writes set configuration
    if (reg_req.req) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 16'h0000;
      if (reg_req.wr) begin
        // Limits and results are read-only to the host
        if (reg_req.addr == ADDR_PWR_CTRL) begin
          s_d.pwr_ctrl = reg_req.wdata;
        end else if (reg_req.addr == ADDR_ALERT_CFG) begin
          s_d.alert_cfg = reg_req.wdata;
        end
        for (int i = 0; i < NUM_STAGES; i++) begin
          if (reg_req.addr == ADDR_SETUP_BASE + ADDR_W'(i)) begin
            s_d.setup[i] = reg_req.wdata;
          end
          // seeds written by host also reload the limits
          if (reg_req.addr == ADDR_SEED_HI_BASE + ADDR_W'(i)) begin
            s_d.seed_hi[i] = reg_req.wdata;
            s_d.lim_hi[i] = reg_req.wdata;
          end
          if (reg_req.addr == ADDR_SEED_LO_BASE + ADDR_W'(i)) begin
            s_d.seed_lo[i] = reg_req.wdata;
            s_d.lim_lo[i] = reg_req.wdata;
          end
        end
      end else begin
        if (reg_req.addr == ADDR_PWR_CTRL) begin
          s_d.rdata = s_q.pwr_ctrl;
        end else if (reg_req.addr == ADDR_ALERT_CFG) begin
          s_d.rdata = s_q.alert_cfg;
        end else if (reg_req.addr == ADDR_ACTIVE) begin
          s_d.rdata = {8'h00, s_q.active};
          // A new event in this cycle keeps the alert set
          if (!new_pulse) begin
            s_d.alert = 1'b0;
          end
        end
        for (int i = 0; i < NUM_STAGES; i++) begin
          if (reg_req.addr == ADDR_RESULT_FIRST + ADDR_W'(i)) begin
            s_d.rdata = s_q.result[i];
          end
          if (reg_req.addr == ADDR_SETUP_BASE + ADDR_W'(i)) begin
            s_d.rdata = s_q.setup[i];
          end
          if (reg_req.addr == ADDR_SEED_HI_BASE + ADDR_W'(i)) begin
            s_d.rdata = s_q.seed_hi[i];
          end
          if (reg_req.addr == ADDR_SEED_LO_BASE + ADDR_W'(i)) begin
            s_d.rdata = s_q.seed_lo[i];
          end
          if (reg_req.addr == ADDR_LIMIT_HI_BASE + ADDR_W'(i)) begin
            s_d.rdata = s_q.lim_hi[i];
          end
          if (reg_req.addr == ADDR_LIMIT_LO_BASE + ADDR_W'(i)) begin
            s_d.rdata = s_q.lim_lo[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.seq <= ST_INIT;
      s_q.cal <= CAL_IDLE;
      s_q.pwr_ctrl <= PWR_CTRL_RESET;
      s_q.alert_cfg <= ALERT_CFG_RESET;
      s_q.setup <= {NUM_STAGES{SETUP_RESET}};
      s_q.seed_hi <= {NUM_STAGES{SEED_HI_RESET}};
      s_q.seed_lo <= {NUM_STAGES{SEED_LO_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // input routed per stage through the switch matrix
  assign conv_stage = s_q.stage;
  assign conv_input_sel = s_q.setup[s_q.stage][SETUP_SEL_LSB +: 3];
  assign conv_setup = s_q.setup[s_q.stage];
  assign conv_start = s_q.start;
  assign conv_power_on = !mode[0] && ((s_q.seq == ST_CONVERT) || (mode == PWR_MODE_FULL));
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign stage_active = s_q.active;
  // open drain: drive only at the asserted level
  assign alert_o = s_q.alert_cfg[ALERT_POL_BIT];
  assign alert_oe_n = ~s_q.alert;
endmodule

// File: testbench/tad_core_chk.sv
// Port-level assertions for the touch activation detect core
`timescale 1ns/1ps
module tad_core_chk #(
  parameter int LP_PERIOD_CYCLES = 50,
  parameter int LP_IDLE_CYCLES = 80
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_clk,
  input wire logic conv_rst_n,
  input wire logic conv_valid,
  input wire logic [tad_pkg::RES_W-1:0] conv_value,
  input wire logic conv_ready,
  input wire logic [2:0] conv_stage,
  input wire logic [2:0] conv_input_sel,
  input wire logic [15:0] conv_setup,
  input wire logic conv_start,
  input wire logic conv_power_on,
  input tad_pkg::tad_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic alert_o,
  input wire logic alert_oe_n,
  input wire logic [tad_pkg::NUM_STAGES-1:0] stage_active
);
  import tad_pkg::*;
  logic act_rd;
  logic pwr_wr;
  assign act_rd = reg_req.req && !reg_req.wr && reg_req.addr == ADDR_ACTIVE;
  assign pwr_wr = reg_req.req && reg_req.wr && reg_req.addr == ADDR_PWR_CTRL;
  sequence s_reg_take;
    reg_req.req;
  endsequence
  sequence s_shutdown_req;
    pwr_wr && reg_req.wdata[0];
  endsequence
  sequence s_full_req;
    pwr_wr && reg_req.wdata[1:0] == PWR_MODE_FULL;
  endsequence
  a_rvalid_follows_req: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg_take |=> reg_rvalid) else $error("read answer missing");
  a_rvalid_has_cause: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rvalid |-> $past(reg_req.req)) else $error("answer without request");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_req.req |=> $stable(reg_rdata)) else $error("read data moved without request");
  a_unmapped_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_req.req && !reg_req.wr && reg_req.addr == 10'h3FF |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_alert_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !alert_oe_n && !act_rd && !$past(act_rd) |=> !alert_oe_n) else $error("alert dropped early");
  a_shutdown_powers_off: assert property (@(posedge clk) disable iff (!rst_n)
    s_shutdown_req |-> ##[1:4] !conv_power_on) else $error("shutdown left power on");
  a_full_powers_on: assert property (@(posedge clk) disable iff (!rst_n)
    s_full_req |-> ##[1:4] conv_power_on) else $error("full power not applied");
  a_start_is_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    conv_start |=> !conv_start) else $error("sequence start longer than a cycle");
  a_ready_drops: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    conv_valid && conv_ready |=> !conv_ready) else $error("second sample taken while crossing");
endmodule
bind tad_core tad_core_chk #(.LP_PERIOD_CYCLES(LP_PERIOD_CYCLES), .LP_IDLE_CYCLES(LP_IDLE_CYCLES)) i_tad_core_chk (
  .clk(clk), .rst_n(rst_n), .conv_clk(conv_clk), .conv_rst_n(conv_rst_n), .conv_valid(conv_valid),
  .conv_value(conv_value), .conv_ready(conv_ready), .conv_stage(conv_stage), .conv_input_sel(conv_input_sel),
  .conv_setup(conv_setup), .conv_start(conv_start), .conv_power_on(conv_power_on), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
  .stage_active(stage_active)
);

// File: testbench/tad_conv_model.sv
// Behavioural converter handing stage results across the link clock
`timescale 1ns/1ps
module tad_conv_model (
  input wire logic conv_clk,
  output logic conv_valid,
  output logic [15:0] conv_value,
  input wire logic conv_ready
);
  initial begin
    conv_valid = 1'b0;
    conv_value = 16'h0000;
  end
  // one unsigned result per stage, stages in order
  task automatic send(input logic [15:0] v);
    int n;
    @(posedge conv_clk);
    #0.5;
    conv_valid = 1'b1;
    conv_value = v;
    n = 0;
    do begin
      @(posedge conv_clk);
      n++;
    end while (conv_ready !== 1'b1 && n < 100);
    // A result that is never taken is a failure, not a silent skip
    if (conv_ready !== 1'b1) begin
      tb_top.num_errors++;
    end
    #0.5;
    conv_valid = 1'b0;
    // Released bus shows the inverse so a stale value cannot pass
    conv_value = ~v;
  endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the touch activation detect core
`timescale 1ns/1ps
module tb_top;
  import tad_pkg::*;
  logic clk, rst_n, conv_clk, conv_rst_n, conv_valid, conv_ready, conv_start, conv_power_on;
  logic alert_o, alert_oe_n, reg_rvalid;
  logic [15:0] conv_value, conv_setup, reg_rdata, rd;
  logic [2:0] conv_stage, conv_input_sel;
  logic [NUM_STAGES-1:0] stage_active;
  tad_reg_req_type reg_req;
  int num_errors = 0;
  int total_checks = 0;

  tad_core #(.LP_PERIOD_CYCLES(50), .LP_IDLE_CYCLES(80)) i_tad_core (
    .clk(clk), .rst_n(rst_n), .conv_clk(conv_clk), .conv_rst_n(conv_rst_n), .conv_valid(conv_valid),
    .conv_value(conv_value), .conv_ready(conv_ready), .conv_stage(conv_stage), .conv_input_sel(conv_input_sel),
    .conv_setup(conv_setup), .conv_start(conv_start), .conv_power_on(conv_power_on), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
    .stage_active(stage_active));
  tad_conv_model i_tad_conv_model (.conv_clk(conv_clk), .conv_valid(conv_valid), .conv_value(conv_value),
    .conv_ready(conv_ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Link clock unrelated in phase to the system clock
  initial begin
    conv_clk = 1'b0;
    #1.7;
    forever #3 conv_clk = ~conv_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Answer is registered, so it is read one edge after the request
  task automatic reg_access(input logic wr, input logic [9:0] addr, input logic [15:0] wdata);
    @(posedge clk);
    #2;
    reg_req = '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
    @(posedge clk);
    #2;
    reg_req.req = 1'b0;
    rd = reg_rdata;
    if (!wr) begin
      check("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    end
  endtask
  task automatic rd_chk(input string what, input logic [9:0] addr, input logic [15:0] exp);
    reg_access(1'b0, addr, 16'h0000);
    check(what, rd, exp);
  endtask

  task automatic t_reset_values;
    check("alert_oe_n", {15'h0000, alert_oe_n}, 16'h0001);
    check("power_on", {15'h0000, conv_power_on}, 16'h0001);
    rd_chk("pwr_ctrl", ADDR_PWR_CTRL, PWR_CTRL_RESET);
    rd_chk("alert_cfg", ADDR_ALERT_CFG, ALERT_CFG_RESET);
    rd_chk("limit_hi", ADDR_LIMIT_HI_BASE + 10'h005, SEED_HI_RESET);
    rd_chk("limit_lo", ADDR_LIMIT_LO_BASE + 10'h005, SEED_LO_RESET);
    rd_chk("unmapped", 10'h3FF, 16'h0000);
  endtask
  task automatic t_seeds;
    for (int s = 0; s < 2; s++) begin
      reg_access(1'b1, ADDR_SEED_HI_BASE + 10'(s), 16'h9000);
      reg_access(1'b1, ADDR_SEED_LO_BASE + 10'(s), 16'h7000);
      rd_chk("limit_hi", ADDR_LIMIT_HI_BASE + 10'(s), 16'h9000);
      rd_chk("limit_lo", ADDR_LIMIT_LO_BASE + 10'(s), 16'h7000);
    end
    reg_access(1'b1, ADDR_LIMIT_HI_BASE, 16'h1234);
    rd_chk("limit_ro", ADDR_LIMIT_HI_BASE, 16'h9000);
    rd_chk("result_rst", ADDR_RESULT_FIRST, 16'h0000);
    reg_access(1'b1, ADDR_RESULT_FIRST, 16'h5555);
    rd_chk("result_ro", ADDR_RESULT_FIRST, 16'h0000);
    reg_access(1'b1, ADDR_SETUP_BASE, 16'h0013);
    reg_access(1'b1, ADDR_SETUP_BASE + 10'h001, 16'h0019);
    cycles(4);
    check("input_sel", {13'h0000, conv_input_sel}, 16'h0003);
    check("setup_word", conv_setup, 16'h0013);
  endtask
  task automatic t_sequence;
    reg_access(1'b1, ADDR_ALERT_CFG, 16'h0001);
    reg_access(1'b0, ADDR_ACTIVE, 16'h0000);
    for (int i = 0; i < NUM_STAGES; i++) begin
      i_tad_conv_model.send((i < 2) ? 16'h8000 : 16'h2000 + 16'(i));
      cycles(8);
      if (i == 0) begin
        check("stage_next", {13'h0000, conv_stage}, 16'h0001);
        check("sel_next", {13'h0000, conv_input_sel}, 16'h0001);
      end
    end
    check("stage_wrap", {13'h0000, conv_stage}, 16'h0000);
    for (int i = 0; i < NUM_STAGES; i++) begin
      rd_chk("result", ADDR_RESULT_FIRST + 10'(i), (i < 2) ? 16'h8000 : 16'h2000 + 16'(i));
    end
    check("active_quiet", {14'h0000, stage_active[1:0]}, 16'h0000);
    check("alert_drive", {15'h0000, alert_oe_n}, 16'h0000);
    check("alert_level", {15'h0000, alert_o}, 16'h0001);
    reg_access(1'b0, ADDR_ACTIVE, 16'h0000);
    cycles(2);
    check("alert_clear", {15'h0000, alert_oe_n}, 16'h0001);
  endtask
  task automatic t_touch;
    i_tad_conv_model.send(16'hF000);
    cycles(8);
    check("active0", {15'h0000, stage_active[0]}, 16'h0001);
    check("active1", {15'h0000, stage_active[1]}, 16'h0000);
    i_tad_conv_model.send(16'h0100);
    cycles(8);
    check("active1_neg", {15'h0000, stage_active[1]}, 16'h0001);
    check("touch_alert", {15'h0000, alert_oe_n}, 16'h0000);
    for (int i = 2; i < NUM_STAGES; i++) begin
      i_tad_conv_model.send(16'h2000 + 16'(i));
      cycles(8);
    end
    rd_chk("touch_result", ADDR_RESULT_FIRST, 16'hF000);
    reg_access(1'b0, ADDR_LIMIT_HI_BASE + 10'h002, 16'h0000);
    check("limit_adapt", {15'h0000, rd != SEED_HI_RESET}, 16'h0001);
    reg_access(1'b0, ADDR_ACTIVE, 16'h0000);
  endtask
  task automatic t_power;
    int n;
    for (int m = 0; m < 4; m++) begin
      reg_access(1'b1, ADDR_PWR_CTRL, 16'h0070 | 16'(m));
      cycles(5);
      if (m != 2) begin
        check("power_mode", {15'h0000, conv_power_on}, (m == 0) ? 16'h0001 : 16'h0000);
      end
    end
    // Low power with a touched stage sleeps the short period after each sequence
    reg_access(1'b1, ADDR_PWR_CTRL, 16'h0070 | 16'(PWR_MODE_LOW));
    for (int i = 0; i < NUM_STAGES; i++) begin
      i_tad_conv_model.send((i == 0) ? 16'hF000 : 16'h2000 + 16'(i));
      if (i < NUM_STAGES - 1) begin
        cycles(8);
      end
    end
    n = 0;
    while (conv_power_on !== 1'b0 && n < 400) begin
      cycles(1);
      n++;
    end
    n = 0;
    do begin
      cycles(1);
      n++;
    end while (conv_power_on !== 1'b1 && n < 400);
    check("lp_period", n[15:0], 16'h0032);
    check("lp_start", {15'h0000, conv_start}, 16'h0001);
    reg_access(1'b1, ADDR_PWR_CTRL, 16'h0070);
    cycles(5);
    check("power_back", {15'h0000, conv_power_on}, 16'h0001);
  endtask

  initial begin
    rst_n = 1'b0;
    conv_rst_n = 1'b0;
    reg_req = '0;
    repeat (16) @(posedge clk);
    #2;
    rst_n = 1'b1;
    conv_rst_n = 1'b1;
    cycles(12);
    t_reset_values();
    t_seeds();
    t_sequence();
    t_touch();
    t_power();
    conclude();
  end
  // Scenarios need a few hundred cycles, well under the ten thousand of the limit
  initial begin
    #500000;
    num_errors++;
    conclude();
  end
endmodule
